// ===== rtl/timer0_pkg.sv
package timer0_pkg;
	localparam logic [31:0] ADDR_CTRL_A = 32'h0000_0000;
	localparam logic [31:0] ADDR_CTRL_B = 32'h0000_0004;
	localparam logic [31:0] ADDR_COUNT = 32'h0000_0008;
	localparam logic [31:0] ADDR_CMP_A = 32'h0000_000C;
	localparam logic [31:0] ADDR_CMP_B = 32'h0000_0010;
	localparam logic [31:0] ADDR_MASK = 32'h0000_0014;
	localparam logic [31:0] ADDR_FLAGS = 32'h0000_0018;
	localparam logic [31:0] ADDR_POWER = 32'h0000_001C;
	localparam logic [31:0] ADDR_PRESCALE = 32'h0000_0020;
	localparam int WGM_LO_POS = 0;
	localparam int WGM_HI_POS = 3;
	localparam int CS_POS = 0;
	localparam int FLAG_OVF_POS = 0;
	localparam int FLAG_CMPA_POS = 1;
	localparam int FLAG_CMPB_POS = 2;
	localparam logic [7:0] VAL_BOTTOM = 8'h00;
	localparam logic [7:0] VAL_MAX = 8'hFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic RESET_POWER = 1'b1;
	localparam logic [15:0] RESET_PRESCALE = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_PC_PWM = 3'h1;
	localparam logic [2:0] MODE_CTC = 3'h2;
	localparam logic [2:0] MODE_FAST_PWM = 3'h3;
	localparam logic [2:0] MODE_PC_PWM_A = 3'h5;
	localparam logic [2:0] MODE_FAST_PWM_A = 3'h7;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_INTERNAL = 3'h1;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
endpackage

// ===== rtl/tick_if.sv
interface tick_if;
	logic [2:0] clock_select_field;
	logic [15:0] prescale_div;
	logic external_count_pin;
	logic tick;
	modport src(input clock_select_field, input prescale_div,
		input external_count_pin, output tick);
	modport dst(output clock_select_field, output prescale_div,
		output external_count_pin, input tick);
endinterface

// ===== rtl/timer_clock_gen.sv
module timer_clock_gen (
	input wire logic aclk,
	input wire logic aresetn,
	tick_if.src tk
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [15:0] div;
		logic tick;
	} gen_state_t;
	gen_state_t s_r;
	gen_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = tk.external_count_pin;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		s_nxt.tick = 1'b0;
		case (tk.clock_select_field)
			timer0_pkg::CS_STOP: begin
				s_nxt.div = 16'h0000;
			end
			timer0_pkg::CS_EXT_FALL: begin
				s_nxt.tick = s_r.prev & ~s_r.sync2;
			end
			timer0_pkg::CS_EXT_RISE: begin
				s_nxt.tick = ~s_r.prev & s_r.sync2;
			end
			default: begin
				if (s_r.div >= tk.prescale_div) begin
					s_nxt.div = 16'h0000;
					s_nxt.tick = 1'b1;
				end else begin
					s_nxt.div = s_r.div + 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign tk.tick = s_r.tick;

	a_stop_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
		(tk.clock_select_field == timer0_pkg::CS_STOP)[*2] |-> !tk.tick)
		else $error("tick while stopped");
endmodule

// ===== rtl/timer0_counter_core.sv
//
// Contract
// - Counter and both compares are 8 bits
// - Bottom is counter value zero
// - Max is counter value 0xFF
// - Top is 0xFF or compare A by mode
// - Three flags, each gated by mask bit
// - Clock from prescaler or chosen pin edge
// - Clock select zero stops the counter
// - Clock select lives in control B
// - Each tick clears, increments or decrements
// - Internal top and bottom indications; the top output marks 0xFF in all modes
// - Counter readable and writable any time
// - Software counter write beats counting
// - Continuous compares set compare flags
// - Mode low bits in A, high in B
// - Overflow flag set per mode
// - Compare flag set next tick, write-one clears
// - Compares buffered only in PWM modes
// - Mode 0 wraps, overflow at zero
// - Mode 2 clears on compare A match
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
module timer0_counter_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_count_pin,
	output logic [2:0] irq_request,
	output logic count_top,
	output logic count_bottom
);
	typedef struct packed {
		logic aw_got;
		logic awready;
		logic [31:0] awaddr;
		logic w_got;
		logic wready;
		logic [31:0] wdata;
		logic wstrb0;
		logic wstrb1;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] mode_lo;
		logic mode_hi;
		logic [2:0] clock_select_field;
		logic [7:0] counter_value;
		logic [7:0] compare_value_a;
		logic [7:0] compare_value_b;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [2:0] timer_irq_mask;
		logic [2:0] timer_irq_flags;
		logic power_off;
		logic [15:0] prescale;
		logic down;
		logic block_match;
		logic [2:0] irq;
		logic top;
		logic bottom;
	} core_state_t;
	core_state_t s_r;
	core_state_t s_nxt;

	tick_if tk();
	timer_clock_gen u_clk (
		.aclk(aclk),
		.aresetn(aresetn),
		.tk(tk.src)
	);

	function automatic logic is_pwm(input logic [2:0] m);
		return (m == timer0_pkg::MODE_PC_PWM) ||
			(m == timer0_pkg::MODE_FAST_PWM) ||
			(m == timer0_pkg::MODE_PC_PWM_A) ||
			(m == timer0_pkg::MODE_FAST_PWM_A);
	endfunction

	logic [2:0] mode;
	logic [7:0] top_val;
	logic tick;
	logic wr_go;
	logic rd_go;
	logic pc_mode;
	assign mode = {s_r.mode_hi, s_r.mode_lo};
	assign top_val = (mode == timer0_pkg::MODE_CTC ||
		mode == timer0_pkg::MODE_PC_PWM_A ||
		mode == timer0_pkg::MODE_FAST_PWM_A) ?
		s_r.compare_value_a : timer0_pkg::VAL_MAX;
	assign pc_mode = (mode == timer0_pkg::MODE_PC_PWM) ||
		(mode == timer0_pkg::MODE_PC_PWM_A);
	assign tick = tk.tick & ~s_r.power_off &
		(s_r.clock_select_field != timer0_pkg::CS_STOP);
	assign wr_go = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
	assign rd_go = s_axi_arvalid & ~s_r.rvalid;
	assign tk.clock_select_field = s_r.clock_select_field;
	assign tk.prescale_div = s_r.prescale;
	assign tk.external_count_pin = external_count_pin;

	always_comb begin
		logic [7:0] wb;
		logic [7:0] nc;
		logic at_top;
		logic at_bot;
		logic [2:0] set;
		logic [2:0] clr;
		s_nxt = s_r;
		wb = s_r.wdata[7:0];
		nc = s_r.counter_value;
		at_top = s_r.counter_value == top_val;
		at_bot = s_r.counter_value == timer0_pkg::VAL_BOTTOM;
		set = 3'h0;
		clr = 3'h0;
		if (s_axi_awvalid && !s_r.aw_got) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_got) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb0 = s_axi_wstrb[0];
			s_nxt.wstrb1 = s_axi_wstrb[1];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (tick) begin
			if (!s_r.block_match &&
				s_r.counter_value == s_r.compare_value_a) begin
				set[timer0_pkg::FLAG_CMPA_POS] = 1'b1;
			end
			if (!s_r.block_match &&
				s_r.counter_value == s_r.compare_value_b) begin
				set[timer0_pkg::FLAG_CMPB_POS] = 1'b1;
			end
			s_nxt.block_match = 1'b0;
			if (pc_mode) begin
				if (s_r.down) begin
					nc = s_r.counter_value - 8'h01;
					if (s_r.counter_value == 8'h01) begin
						s_nxt.down = 1'b0;
					end
				end else if (at_top) begin
					nc = s_r.counter_value - 8'h01;
					s_nxt.down = 1'b1;
				end else begin
					nc = s_r.counter_value + 8'h01;
				end
				if (at_bot) begin
					set[timer0_pkg::FLAG_OVF_POS] = 1'b1;
				end
			end else if (at_top && mode != timer0_pkg::MODE_NORMAL) begin
				nc = timer0_pkg::VAL_BOTTOM;
				if (mode != timer0_pkg::MODE_CTC) begin
					set[timer0_pkg::FLAG_OVF_POS] = 1'b1;
				end
			end else begin
				nc = s_r.counter_value + 8'h01;
				if (s_r.counter_value == timer0_pkg::VAL_MAX) begin
					set[timer0_pkg::FLAG_OVF_POS] = 1'b1;
				end
			end
			if (is_pwm(mode) && ((pc_mode && at_top) ||
				(!pc_mode && nc == timer0_pkg::VAL_BOTTOM))) begin
				s_nxt.compare_value_a = s_r.buf_a;
				s_nxt.compare_value_b = s_r.buf_b;
			end
		end
		s_nxt.counter_value = nc;
		if (wr_go) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = timer0_pkg::RESP_OKAY;
			if (s_r.wstrb0) begin
				case (s_r.awaddr)
					timer0_pkg::ADDR_CTRL_A: begin
						s_nxt.mode_lo = wb[timer0_pkg::WGM_LO_POS +: 2];
					end
					timer0_pkg::ADDR_CTRL_B: begin
						s_nxt.mode_hi = wb[timer0_pkg::WGM_HI_POS];
						s_nxt.clock_select_field =
							wb[timer0_pkg::CS_POS +: 3];
					end
					timer0_pkg::ADDR_COUNT: begin
						s_nxt.counter_value = wb;
						s_nxt.block_match = 1'b1;
					end
					timer0_pkg::ADDR_CMP_A: begin
						s_nxt.buf_a = wb;
						if (!is_pwm(mode)) begin
							s_nxt.compare_value_a = wb;
						end
					end
					timer0_pkg::ADDR_CMP_B: begin
						s_nxt.buf_b = wb;
						if (!is_pwm(mode)) begin
							s_nxt.compare_value_b = wb;
						end
					end
					timer0_pkg::ADDR_MASK: begin
						s_nxt.timer_irq_mask = wb[2:0];
					end
					timer0_pkg::ADDR_FLAGS: begin
						clr = wb[2:0];
					end
					timer0_pkg::ADDR_POWER: begin
						s_nxt.power_off = wb[0];
					end
					timer0_pkg::ADDR_PRESCALE: begin
						s_nxt.prescale[7:0] = wb;
					end
					default: begin
						s_nxt.bresp = timer0_pkg::RESP_SLVERR;
					end
				endcase
			end
			if (s_r.wstrb1 && s_r.awaddr == timer0_pkg::ADDR_PRESCALE) begin
				s_nxt.prescale[15:8] = s_r.wdata[15:8];
			end
		end
		s_nxt.timer_irq_flags = (s_r.timer_irq_flags & ~clr) | set;
		if (rd_go) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = timer0_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				timer0_pkg::ADDR_CTRL_A: s_nxt.rdata[1:0] = s_r.mode_lo;
				timer0_pkg::ADDR_CTRL_B: s_nxt.rdata[3:0] =
					{s_r.mode_hi, s_r.clock_select_field};
				timer0_pkg::ADDR_COUNT: s_nxt.rdata[7:0] = s_r.counter_value;
				timer0_pkg::ADDR_CMP_A: s_nxt.rdata[7:0] =
					is_pwm(mode) ? s_r.buf_a : s_r.compare_value_a;
				timer0_pkg::ADDR_CMP_B: s_nxt.rdata[7:0] =
					is_pwm(mode) ? s_r.buf_b : s_r.compare_value_b;
				timer0_pkg::ADDR_MASK: s_nxt.rdata[2:0] = s_r.timer_irq_mask;
				timer0_pkg::ADDR_FLAGS: s_nxt.rdata[2:0] = s_r.timer_irq_flags;
				timer0_pkg::ADDR_POWER: s_nxt.rdata[0] = s_r.power_off;
				timer0_pkg::ADDR_PRESCALE: s_nxt.rdata[15:0] = s_r.prescale;
				default: s_nxt.rresp = timer0_pkg::RESP_SLVERR;
			endcase
		end
		s_nxt.irq = s_nxt.timer_irq_flags & s_nxt.timer_irq_mask;
		s_nxt.top = s_nxt.counter_value == timer0_pkg::VAL_MAX;
		s_nxt.bottom = s_nxt.counter_value == timer0_pkg::VAL_BOTTOM;
		s_nxt.awready = ~s_nxt.aw_got;
		s_nxt.wready = ~s_nxt.w_got;
		s_nxt.arready = ~s_nxt.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.power_off <= timer0_pkg::RESET_POWER;
			s_r.prescale <= timer0_pkg::RESET_PRESCALE;
			s_r.bottom <= 1'b1;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign irq_request = s_r.irq;
	assign count_top = s_r.top;
	assign count_bottom = s_r.bottom;

	sequence wrap_seq;
		tick && !wr_go && mode == timer0_pkg::MODE_NORMAL &&
			s_r.counter_value == timer0_pkg::VAL_MAX;
	endsequence
	a_normal_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap_seq |=> s_r.counter_value == 8'h00 &&
			s_r.timer_irq_flags[0])
		else $error("normal mode wrap wrong");
	a_ctc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && !wr_go && mode == timer0_pkg::MODE_CTC &&
			s_r.counter_value == s_r.compare_value_a
			|=> s_r.counter_value == 8'h00)
		else $error("ctc clear missing");
	a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.clock_select_field == timer0_pkg::CS_STOP && !wr_go
			|=> $stable(s_r.counter_value))
		else $error("counter moved while stopped");
	a_write_wins: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && s_r.wstrb0 && s_r.awaddr == timer0_pkg::ADDR_COUNT
			|=> s_r.counter_value == $past(s_r.wdata[7:0]))
		else $error("counter write lost");
	a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_request == (s_r.timer_irq_flags &
			s_r.timer_irq_mask))
		else $error("irq gating wrong");
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.timer_irq_flags[1] && !(wr_go &&
			s_r.awaddr == timer0_pkg::ADDR_FLAGS)
			|=> s_r.timer_irq_flags[1])
		else $error("compare flag dropped");
	a_top_ind: assert property (@(posedge aclk) disable iff (!aresetn)
		count_top == (s_r.counter_value == 8'hFF))
		else $error("top indication wrong");
	a_bottom_ind: assert property (@(posedge aclk) disable iff (!aresetn)
		count_bottom == (s_r.counter_value == 8'h00))
		else $error("bottom indication wrong");
	a_power_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.power_off && !wr_go |=> $stable(s_r.counter_value))
		else $error("counter moved while powered off");
endmodule

// ===== dv/ext_event_src.sv
module ext_event_src (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic [7:0] npulse,
	output logic pin,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ph;
	logic [7:0] left;
	// Pulse train: 8 clocks high, 8 low, pin idles low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin <= 1'b0;
			busy <= 1'b0;
			ph <= 4'h0;
			left <= 8'h00;
		end else if (!busy) begin
			pin <= 1'b0;
			if (go && npulse != 8'h00) begin
				busy <= 1'b1;
				left <= npulse;
				ph <= 4'h0;
			end
		end else begin
			ph <= ph + 4'h1;
			pin <= (ph < 4'h8);
			if (ph == 4'hF) begin
				left <= left - 8'h01;
				if (left == 8'h01) begin
					busy <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== dv/timer0_counter_core_tb.sv
module timer0_counter_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, top, bottom, pin, go, busy;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] irq;
	logic [7:0] npulse;
	int errors, checked;

	timer0_counter_core DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .external_count_pin(pin),
		.irq_request(irq), .count_top(top), .count_bottom(bottom));
	ext_event_src src (.aclk(aclk), .aresetn(aresetn), .go(go),
		.npulse(npulse), .pin(pin), .busy(busy));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_out(input string nm, input logic [2:0] e, input logic [2:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF,
		input logic [1:0] er = timer0_pkg::RESP_OKAY);
		int n;
		logic ap, wp, ta, tw;
		ap = 1'b1;
		wp = 1'b1;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while ((ap || wp) && n < 100) begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			n++;
			@(posedge aclk);
			if (ap && ta === 1'b1) begin
				ap = 1'b0;
				awvalid <= 1'b0;
			end
			if (wp && tw === 1'b1) begin
				wp = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(negedge aclk);
			n++;
		end while (bvalid !== 1'b1 && n < 200);
		if (bvalid !== 1'b1) errors++;
		chk_resp("bresp", er, bresp);
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task rd(input logic [31:0] a, input logic [31:0] e,
		input logic [1:0] er = timer0_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 100);
		@(posedge aclk);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < 200);
		if (rvalid !== 1'b1) errors++;
		chk_data("rdata", e, rdata);
		chk_resp("rresp", er, rresp);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Wait for irq bit k, or count_top when k is 3
	task wait_hi(input int k);
		int n;
		logic v;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			v = (k == 3) ? top : irq[k];
		end while (v !== 1'b1 && n < 1000);
		chk_out("wait_level", 3'h1, {2'b00, v});
	endtask

	task pulses(input logic [7:0] cnt);
		int n;
		n = 0;
		@(posedge aclk);
		go <= 1'b1;
		npulse <= cnt;
		@(posedge aclk);
		go <= 1'b0;
		do begin
			@(negedge aclk);
			n++;
		end while (busy !== 1'b0 && n < 2000);
		if (busy !== 1'b0) errors++;
		repeat (8) @(posedge aclk);
	endtask

	task tdone(input string nm);
		$display("test %s done", nm);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#400000;
		errors++;
		wrap_up;
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, go} = 6'h00;
		awaddr = 32'h0;
		wdata = 32'h0;
		araddr = 32'h0;
		wstrb = 4'h0;
		npulse = 8'h00;
		errors = 0;
		checked = 0;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk_out("irq_request", 3'h0, irq);
		chk_out("bottom_top", 3'h2, {1'b0, bottom, top});
		rd(timer0_pkg::ADDR_COUNT, 32'h0);
		rd(timer0_pkg::ADDR_POWER, 32'h1);
		rd(timer0_pkg::ADDR_FLAGS, 32'h0);
		rd(32'h40, 32'h0, timer0_pkg::RESP_SLVERR);
		wr(32'h40, 32'hFF, 4'hF, timer0_pkg::RESP_SLVERR);
		wr(timer0_pkg::ADDR_CTRL_A, 32'h3);
		rd(timer0_pkg::ADDR_CTRL_A, 32'h3);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h8);
		rd(timer0_pkg::ADDR_CTRL_B, 32'h8);
		wr(timer0_pkg::ADDR_CTRL_A, 32'h0);
		tdone("reset_and_map");
		wr(timer0_pkg::ADDR_PRESCALE, 32'h0);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h1);
		wr(timer0_pkg::ADDR_COUNT, 32'h1AB);
		repeat (30) @(posedge aclk);
		rd(timer0_pkg::ADDR_COUNT, 32'hAB);
		wr(timer0_pkg::ADDR_POWER, 32'h0);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h0);
		wr(timer0_pkg::ADDR_COUNT, 32'h5);
		repeat (30) @(posedge aclk);
		rd(timer0_pkg::ADDR_COUNT, 32'h5);
		wr(timer0_pkg::ADDR_COUNT, 32'h77, 4'h0);
		rd(timer0_pkg::ADDR_COUNT, 32'h5);
		tdone("power_and_stop");
		wr(timer0_pkg::ADDR_PRESCALE, 32'h63);
		wr(timer0_pkg::ADDR_CMP_A, 32'h40);
		wr(timer0_pkg::ADDR_CMP_B, 32'h40);
		wr(timer0_pkg::ADDR_COUNT, 32'hFE);
		wr(timer0_pkg::ADDR_MASK, 32'h1);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h1);
		wait_hi(3);
		rd(timer0_pkg::ADDR_COUNT, 32'hFF);
		wait_hi(0);
		rd(timer0_pkg::ADDR_COUNT, 32'h0);
		chk_out("bottom_top", 3'h2, {1'b0, bottom, top});
		rd(timer0_pkg::ADDR_FLAGS, 32'h1);
		wr(timer0_pkg::ADDR_FLAGS, 32'h1);
		rd(timer0_pkg::ADDR_FLAGS, 32'h0);
		tdone("normal_wrap");
		wr(timer0_pkg::ADDR_CTRL_B, 32'h0);
		wr(timer0_pkg::ADDR_CTRL_A, 32'h2);
		wr(timer0_pkg::ADDR_CMP_A, 32'h3);
		wr(timer0_pkg::ADDR_CMP_B, 32'h2);
		wr(timer0_pkg::ADDR_COUNT, 32'h0);
		wr(timer0_pkg::ADDR_FLAGS, 32'h7);
		wr(timer0_pkg::ADDR_MASK, 32'h2);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h1);
		wait_hi(1);
		rd(timer0_pkg::ADDR_COUNT, 32'h0);
		rd(timer0_pkg::ADDR_FLAGS, 32'h6);
		chk_out("irq_request", 3'h2, irq);
		wr(timer0_pkg::ADDR_MASK, 32'h0);
		repeat (2) @(negedge aclk);
		chk_out("irq_request", 3'h0, irq);
		tdone("clear_on_match");
		wr(timer0_pkg::ADDR_CTRL_B, 32'h0);
		wr(timer0_pkg::ADDR_CTRL_A, 32'h0);
		wr(timer0_pkg::ADDR_COUNT, 32'h0);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h7);
		pulses(8'h05);
		rd(timer0_pkg::ADDR_COUNT, 32'h5);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h6);
		pulses(8'h03);
		rd(timer0_pkg::ADDR_COUNT, 32'h8);
		tdone("external_pin");
		wr(timer0_pkg::ADDR_CTRL_A, 32'h3);
		wr(timer0_pkg::ADDR_COUNT, 32'h4);
		wr(timer0_pkg::ADDR_CMP_A, 32'h5);
		wr(timer0_pkg::ADDR_FLAGS, 32'h7);
		wr(timer0_pkg::ADDR_CTRL_B, 32'h7);
		pulses(8'h02);
		rd(timer0_pkg::ADDR_COUNT, 32'h6);
		rd(timer0_pkg::ADDR_FLAGS, 32'h0);
		rd(timer0_pkg::ADDR_CMP_A, 32'h5);
		tdone("pwm_buffer");
		wrap_up;
	end
endmodule
